// File: hdl/timer_pkg.sv
// Constants for the 8-bit prescaled compare timer and its APB register map.
// Assumes a 32-bit APB with byte addresses and one aligned word per register.
// Functional notes
// (RULE1) Clock select: 0 stops, n divides by 2^(n-1)
// (RULE2) Stop code acts as timer enable
// (RULE3) PWM B: counter clears cycle after C match
// (RULE4) B output mode: off, toggle, clear, set
// (RULE5) Pins driven only when direction bit set
// (RULE6) Force B applies B action, no flag
// (RULE7) Force B uses mode bits written together
// (RULE8) Force B reads zero, ignored in PWM B
// (RULE9) Force A likewise for A pin
// (RULE10) Prescaler reset keeps counter, self clears, reads zero
// (RULE11) Counter is 8-bit read/write up counter
// (RULE12) Counter write lands 1.5 or 1 cycles later; sync mode takes 2 cycles here
// (RULE13) Match only when counting, not on write
// (RULE14) A match sets A flag after delay
// (RULE15) B match sets B flag after delay
// (RULE16) Clear-on-top clears counter on C match
// (RULE17) A flag, enable, global bit: vector 003
// (RULE18) B flag, enable, global bit: vector 009
// (RULE19) Compare registers A, B, C read/write
// (RULE20) Mask bit 7 reads zero
// (RULE21) Async enable picks fast source, else core
// (RULE22) Everything resets to zero, timer halted
package timer_pkg;
    localparam logic [7:0] ADDR_MAIN_CTRL = 8'h00;
    localparam logic [7:0] ADDR_GEN_CTRL  = 8'h04;
    localparam logic [7:0] ADDR_COUNTER   = 8'h08;
    localparam logic [7:0] ADDR_CMP_A     = 8'h0c;
    localparam logic [7:0] ADDR_CMP_B     = 8'h10;
    localparam logic [7:0] ADDR_CMP_C     = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;
    localparam logic [7:0] ADDR_FLAGS     = 8'h1c;

    // Main control fields
    localparam int BIT_CTC    = 7;
    localparam int BIT_PWM_A  = 6;
    localparam int COM_A_LO   = 4;
    localparam int CS_LO      = 0;
    // General control fields
    localparam int BIT_PWM_B  = 6;
    localparam int COM_B_LO   = 4;
    localparam int BIT_FOC_B  = 3;
    localparam int BIT_FOC_A  = 2;
    localparam int BIT_PSR    = 1;
    // Mask and flag fields
    localparam int BIT_IRQ_A  = 6;
    localparam int BIT_IRQ_B  = 5;

    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_TOGGLE = 2'h1;
    localparam logic [1:0] MODE_CLEAR  = 2'h2;
    localparam logic [1:0] MODE_SET    = 2'h3;

    localparam logic [3:0] CS_STOP     = 4'h0;
    localparam int         PRESCALE_W  = 14;

    // Counter write latency in whole cycles (1.5 rounds up in sync mode)
    localparam logic [1:0] LOAD_WAIT_SYNC  = 2'h2;
    localparam logic [1:0] LOAD_WAIT_ASYNC = 2'h1;

    localparam logic [7:0] VECTOR_CMP_A = 8'h03;
    localparam logic [7:0] VECTOR_CMP_B = 8'h09;
    localparam logic [7:0] VECTOR_NONE  = 8'h00;
    localparam logic [7:0] COUNT_ONE    = 8'h01;
    localparam logic [7:0] ZERO_8       = 8'h00;
endpackage : timer_pkg

// File: hdl/timer_prescaler.sv
// Prescaler: divides the selected source enable by 2^(code-1).
// Assumes src_tick is a one-cycle enable synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module timer_prescaler
    import timer_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       src_tick,
    input  wire logic       clear,
    input  wire logic [3:0] cs,
    output logic            tick
);
    typedef struct packed {
        logic [PRESCALE_W-1:0] count;
        logic                  tick;
    } pre_state_t;

    pre_state_t s_reg;
    pre_state_t s_next;

    function automatic logic [PRESCALE_W-1:0] div_mask(input logic [3:0] code);
        logic [PRESCALE_W:0] one_hot;
        one_hot = '0;
        one_hot[code - 4'h1] = 1'b1;
        div_mask = one_hot[PRESCALE_W-1:0] - 14'h0001;
    endfunction : div_mask

    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (clear) begin
            s_next.count = '0;                                          // RULE10
        end else if (src_tick) begin
            s_next.count = s_reg.count + 14'h0001;
            if (cs != CS_STOP) begin                                    // RULE2
                s_next.tick = (s_reg.count & div_mask(cs)) == div_mask(cs); // RULE1
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

    halt_no_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
        cs == CS_STOP |=> !tick) else $error("tick while stopped"); // RULE2
endmodule : timer_prescaler
`default_nettype wire

// File: hdl/timer_top.sv
// Timer core: 8-bit up counter, three compare registers, pins, APB slave.
// Assumes synchronous inputs; fast_source_tick is a pclk-synchronous enable.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module timer_top
    import timer_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        async_source_enable,
    input  wire logic        fast_source_tick,
    input  wire logic        global_irq_enable,
    input  wire logic        dir_a,
    input  wire logic        dir_b,
    output logic             compare_a_pin,
    output logic             compare_a_pin_oe,
    output logic             compare_b_pin,
    output logic             compare_b_pin_oe,
    output logic             compare_b_pin_n,
    output logic             compare_b_pin_n_oe,
    output logic             irq_compare_a,
    output logic             irq_compare_b,
    output logic [7:0]       irq_vector
);
    typedef struct packed {
        logic        ctc;
        logic        pwm_a;
        logic [1:0]  com_a;
        logic [3:0]  cs;
        logic        pwm_b;
        logic [1:0]  com_b;
        logic        psr;
        logic [7:0]  cnt;
        logic [7:0]  ocr_a;
        logic [7:0]  ocr_b;
        logic [7:0]  ocr_c;
        logic        ie_a;
        logic        ie_b;
        logic        flag_a;
        logic        flag_b;
        logic [7:0]  load_val;
        logic [1:0]  load_wait;
        logic        top_clear;
        logic        match_a_d;
        logic        match_b_d;
        logic        pin_a;
        logic        pin_b;
        logic        pin_b_n;
        logic        oe_a;
        logic        oe_b;
        logic        oe_b_n;
        logic        irq_a;
        logic        irq_b;
        logic [7:0]  irq_vec;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic   tick;
    logic   src_tick;
    logic   [7:0] inc;
    logic   match_a;
    logic   match_b;
    logic   match_c;
    logic   acc;
    logic   wr;

    // Non-PWM compare action
    function automatic logic pin_action(input logic [1:0] mode, input logic cur);
        unique case (mode)
            MODE_TOGGLE: pin_action = ~cur;
            MODE_CLEAR:  pin_action = 1'b0;
            MODE_SET:    pin_action = 1'b1;
            MODE_OFF:    pin_action = cur;
        endcase
    endfunction : pin_action

    // PWM level: set mode sets on match, others clear on match; all flip back at one
    function automatic logic pwm_level(input logic [1:0] mode, input logic hit,
                                       input logic at_one, input logic cur);
        if (hit) begin
            pwm_level = (mode == MODE_SET);
        end else if (at_one) begin
            pwm_level = (mode != MODE_SET);
        end else begin
            pwm_level = cur;
        end
    endfunction : pwm_level

    assign src_tick = async_source_enable ? fast_source_tick : 1'b1; // RULE21

    timer_prescaler u_prescaler (
        .pclk     (pclk),
        .presetn  (presetn),
        .src_tick (src_tick),
        .clear    (s_reg.psr),
        .cs       (s_reg.cs),
        .tick     (tick)
    );

    assign inc     = s_reg.cnt + COUNT_ONE;
    // A load or a pending top clear owns the counter, so neither can match
    assign acc     = tick && (s_reg.load_wait == 2'h0) && !s_reg.top_clear;
    assign match_a = acc && (inc == s_reg.ocr_a); // RULE13
    assign match_b = acc && (inc == s_reg.ocr_b); // RULE13
    assign match_c = acc && (inc == s_reg.ocr_c); // RULE13
    // Write takes effect on the edge where pready is seen high
    assign wr      = psel && penable && pwrite && s_reg.pready;

    always_comb begin
        s_next = s_reg;
        s_next.psr = 1'b0;                                               // RULE10
        s_next.match_a_d = match_a;
        s_next.match_b_d = match_b;

        // Counter
        s_next.top_clear = match_c && (s_reg.ctc || s_reg.pwm_a || s_reg.pwm_b); // RULE16 RULE3
        if (s_reg.top_clear) begin
            s_next.cnt = ZERO_8;                                         // RULE3 RULE16
        end else if (s_reg.load_wait == 2'h1) begin
            s_next.cnt = s_reg.load_val;                                 // RULE12
            s_next.load_wait = 2'h0;
        end else if (s_reg.load_wait != 2'h0) begin
            s_next.load_wait = s_reg.load_wait - 2'h1;
        end else if (acc) begin
            s_next.cnt = inc;                                            // RULE11
        end

        // Flags land two cycles after the match, one cycle after the counter reaches the compare value
        if (s_reg.match_a_d) begin
            s_next.flag_a = 1'b1;                                        // RULE14
        end else if (wr && paddr == ADDR_FLAGS && pwdata[BIT_IRQ_A]) begin
            s_next.flag_a = 1'b0;
        end
        if (s_reg.match_b_d) begin
            s_next.flag_b = 1'b1;                                        // RULE15
        end else if (wr && paddr == ADDR_FLAGS && pwdata[BIT_IRQ_B]) begin
            s_next.flag_b = 1'b0;
        end

        // Pins on match
        if (s_reg.pwm_a) begin
            s_next.pin_a = pwm_level(s_reg.com_a, match_a, acc && inc == COUNT_ONE, s_reg.pin_a);
        end else if (match_a) begin
            s_next.pin_a = pin_action(s_reg.com_a, s_reg.pin_a);
        end
        if (s_reg.pwm_b) begin
            s_next.pin_b = pwm_level(s_reg.com_b, match_b, acc && inc == COUNT_ONE, s_reg.pin_b);
        end else if (match_b) begin
            s_next.pin_b = pin_action(s_reg.com_b, s_reg.pin_b);         // RULE4
        end

        // Register writes
        if (wr) begin
            unique case (paddr)
                ADDR_MAIN_CTRL: begin
                    s_next.ctc   = pwdata[BIT_CTC];
                    s_next.pwm_a = pwdata[BIT_PWM_A];
                    s_next.com_a = pwdata[COM_A_LO +: 2];
                    s_next.cs    = pwdata[CS_LO +: 4];                   // RULE1 RULE2
                end
                ADDR_GEN_CTRL: begin
                    s_next.pwm_b = pwdata[BIT_PWM_B];
                    s_next.com_b = pwdata[COM_B_LO +: 2];
                    s_next.psr   = pwdata[BIT_PSR];                      // RULE10
                    if (pwdata[BIT_FOC_B] && !pwdata[BIT_PWM_B]) begin   // RULE8
                        s_next.pin_b = pin_action(pwdata[COM_B_LO +: 2], s_reg.pin_b); // RULE6 RULE7
                    end
                    if (pwdata[BIT_FOC_A] && !s_reg.pwm_a) begin
                        s_next.pin_a = pin_action(s_reg.com_a, s_reg.pin_a); // RULE9
                    end
                end
                ADDR_COUNTER: begin
                    s_next.load_val  = pwdata[7:0];
                    s_next.load_wait = async_source_enable ? LOAD_WAIT_ASYNC
                                                           : LOAD_WAIT_SYNC; // RULE12
                end
                ADDR_CMP_A: s_next.ocr_a = pwdata[7:0];                  // RULE19
                ADDR_CMP_B: s_next.ocr_b = pwdata[7:0];                  // RULE19
                ADDR_CMP_C: s_next.ocr_c = pwdata[7:0];                  // RULE19
                ADDR_IRQ_MASK: begin
                    s_next.ie_a = pwdata[BIT_IRQ_A];
                    s_next.ie_b = pwdata[BIT_IRQ_B];
                end
                default: begin
                end
            endcase
        end

        // Pin drive follows direction bit and mode
        s_next.oe_a   = dir_a && (s_next.com_a != MODE_OFF);             // RULE5
        s_next.oe_b   = dir_b && (s_next.com_b != MODE_OFF);             // RULE5
        s_next.oe_b_n = dir_b && s_next.pwm_b && (s_next.com_b == MODE_TOGGLE); // RULE5
        s_next.pin_b_n = ~s_next.pin_b;

        // Interrupt requests, A has priority for the vector
        s_next.irq_a = s_reg.flag_a && s_reg.ie_a && global_irq_enable;  // RULE17
        s_next.irq_b = s_reg.flag_b && s_reg.ie_b && global_irq_enable;  // RULE18
        s_next.irq_vec = s_next.irq_a ? VECTOR_CMP_A
                       : s_next.irq_b ? VECTOR_CMP_B : VECTOR_NONE;

        // APB: one wait state, answer registered
        s_next.pready  = psel && penable && !s_reg.pready;
        s_next.pslverr = 1'b0;
        s_next.prdata  = '0;
        if (psel && penable && !s_reg.pready) begin
            unique case (paddr)
                ADDR_MAIN_CTRL: s_next.prdata[7:0] = {s_reg.ctc, s_reg.pwm_a,
                                                      s_reg.com_a, s_reg.cs};
                ADDR_GEN_CTRL:  s_next.prdata[7:0] = {1'b0, s_reg.pwm_b, s_reg.com_b,
                                                      4'h0};             // RULE8 RULE10
                ADDR_COUNTER:   s_next.prdata[7:0] = s_reg.cnt;          // RULE11
                ADDR_CMP_A:     s_next.prdata[7:0] = s_reg.ocr_a;
                ADDR_CMP_B:     s_next.prdata[7:0] = s_reg.ocr_b;
                ADDR_CMP_C:     s_next.prdata[7:0] = s_reg.ocr_c;
                ADDR_IRQ_MASK:  s_next.prdata[7:0] = {1'b0, s_reg.ie_a,
                                                      s_reg.ie_b, 5'h00}; // RULE20
                ADDR_FLAGS:     s_next.prdata[7:0] = {1'b0, s_reg.flag_a,
                                                      s_reg.flag_b, 5'h00};
                default:        s_next.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;                                                 // RULE22
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata             = s_reg.prdata;
    assign pready             = s_reg.pready;
    assign pslverr            = s_reg.pslverr;
    assign compare_a_pin      = s_reg.pin_a;
    assign compare_a_pin_oe   = s_reg.oe_a;
    assign compare_b_pin      = s_reg.pin_b;
    assign compare_b_pin_oe   = s_reg.oe_b;
    assign compare_b_pin_n    = s_reg.pin_b_n;
    assign compare_b_pin_n_oe = s_reg.oe_b_n;
    assign irq_compare_a      = s_reg.irq_a;
    assign irq_compare_b      = s_reg.irq_b;
    assign irq_vector         = s_reg.irq_vec;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    stop_holds_count_a: assert property ((s_reg.cs == CS_STOP && s_reg.load_wait == 2'h0
        && !s_reg.top_clear && !tick) |=> s_reg.cnt == $past(s_reg.cnt))
        else $error("counter moved while stopped"); // RULE2
    top_clear_a: assert property ((match_c && s_reg.pwm_b) |=> s_reg.top_clear ##1
        s_reg.cnt == ZERO_8) else $error("no clear after top match"); // RULE3
    toggle_b_a: assert property ((match_b && !s_reg.pwm_b && s_reg.com_b == MODE_TOGGLE
        && !wr) |=> s_reg.pin_b != $past(s_reg.pin_b)) else $error("B did not toggle"); // RULE4
    inv_b_off_a: assert property (!s_reg.pwm_b |-> !compare_b_pin_n_oe)
        else $error("inverted B driven outside PWM"); // RULE5
    strobes_zero_a: assert property ((pready && !pwrite && $past(paddr) == ADDR_GEN_CTRL)
        |-> prdata[3:1] == 3'h0) else $error("strobe read nonzero"); // RULE8
    sync_load_a: assert property ((wr && paddr == ADDR_COUNTER && !async_source_enable)
        ##1 !s_reg.top_clear [*2] |=> s_reg.cnt == $past(s_reg.load_val))
        else $error("late counter load"); // RULE12
    flag_a_delay_a: assert property (match_a |-> ##2 s_reg.flag_a)
        else $error("A flag not set"); // RULE14
    flag_b_delay_a: assert property (match_b |-> ##2 s_reg.flag_b)
        else $error("B flag not set"); // RULE15
    irq_a_vec_a: assert property ((s_reg.flag_a && s_reg.ie_a && global_irq_enable)
        |=> irq_compare_a && irq_vector == VECTOR_CMP_A) else $error("A irq missing"); // RULE17
    mask_res_a: assert property ((pready && !pwrite && $past(paddr) == ADDR_IRQ_MASK)
        |-> !prdata[7]) else $error("reserved mask bit set"); // RULE20

    pwm_b_cycle_c: cover property (s_reg.pwm_b && match_c ##[1:300] match_b);
    force_b_c: cover property (wr && paddr == ADDR_GEN_CTRL && pwdata[BIT_FOC_B]);
    irq_b_c: cover property (irq_compare_b);
endmodule : timer_top
`default_nettype wire

// File: tb/timer1_prescale_compare_regs_test.sv
// Self-checking bench for the prescaled compare timer: APB registers, tick rates,
// compare matches, flags, interrupt requests and compare pins.
// Assumes timer_pkg and timer_top are compiled first; the bench is the only APB master.
`timescale 1ns/1ns
`default_nettype none
module timer1_prescale_compare_regs_test;
    import timer_pkg::*;

    logic        pclk = 1'b0;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        async_source_enable;
    logic        fast_source_tick;
    logic        global_irq_enable;
    logic        dir_a;
    logic        dir_b;
    logic        compare_a_pin;
    logic        compare_a_pin_oe;
    logic        compare_b_pin;
    logic        compare_b_pin_oe;
    logic        compare_b_pin_n;
    logic        compare_b_pin_n_oe;
    logic        irq_compare_a;
    logic        irq_compare_b;
    logic [7:0]  irq_vector;
    int          fails;
    int          n_tests;
    logic [31:0] v;
    logic [31:0] c0;
    logic [31:0] c1;
    logic        e;
    logic [7:0]  d;
    logic [7:0]  mx;
    int          k;
    int          n;
    int          s;
    int          ex;
    logic [1:0]  modes [0:4] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
    logic        pins  [0:4] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    timer_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .async_source_enable(async_source_enable), .fast_source_tick(fast_source_tick),
        .global_irq_enable(global_irq_enable), .dir_a(dir_a), .dir_b(dir_b),
        .compare_a_pin(compare_a_pin), .compare_a_pin_oe(compare_a_pin_oe),
        .compare_b_pin(compare_b_pin), .compare_b_pin_oe(compare_b_pin_oe),
        .compare_b_pin_n(compare_b_pin_n), .compare_b_pin_n_oe(compare_b_pin_n_oe),
        .irq_compare_a(irq_compare_a), .irq_compare_b(irq_compare_b),
        .irq_vector(irq_vector)
    );

    always #5 pclk = ~pclk;

    // Fast source runs at half the core rate, and only while selected
    always @(posedge pclk) begin
        fast_source_tick <= async_source_enable & ~fast_source_tick;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] q, output logic err);
        int j;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        j = 0;
        do begin
            @(posedge pclk);
            j++;
        end while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        check(32'(j), 32'h2, "one wait state");
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] q;
        logic        err;
        apb(1'b1, a, wd, q, err);
        check(32'(err), 32'h0, "write error");
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic err;
        apb(1'b0, a, 32'h0, q, err);
        check(32'(err), 32'h0, "read error");
    endtask : rd

    task automatic idle(input int c);
        repeat (c) @(posedge pclk);
    endtask : idle

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    initial begin
        #500000;
        fails++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {async_source_enable, global_irq_enable, dir_a, dir_b} = '0;
        fails = 0;
        n_tests = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'({compare_a_pin_oe, compare_b_pin_oe, compare_b_pin_n_oe,
                   irq_compare_a, irq_compare_b}), 32'h0, "outputs after reset");
        for (k = 0; k < 8; k++) begin
            rd(8'(k * 4), v);
            check(v, 32'h0, "reset value");
        end
        apb(1'b0, 8'h20, 32'h0, v, e);
        check({v[31:1], e}, 32'h1, "unmapped read");
        for (k = 2; k < 6; k++) begin
            wr(8'(k * 4), 32'hffffff5a ^ 32'(k));
            rd(8'(k * 4), v);
            check(v, 32'h5a ^ 32'(k), "register readback");
        end
        wr(ADDR_IRQ_MASK, 32'hff);
        rd(ADDR_IRQ_MASK, v);
        check(32'(v[7:5]), 32'h3, "mask bits");
        wr(ADDR_IRQ_MASK, 32'h0);
        wr(ADDR_GEN_CTRL, 32'h7e);
        rd(ADDR_GEN_CTRL, v);
        check(v, 32'h70, "strobes read zero");
        wr(ADDR_GEN_CTRL, 32'h0);
        wr(ADDR_COUNTER, 32'h33);
        wr(ADDR_GEN_CTRL, 32'h02);
        idle(50);
        rd(ADDR_COUNTER, v);
        check(v, 32'h33, "halted counter kept");
        for (s = 0; s < 2; s++) begin
            async_source_enable <= s[0];
            for (n = 1; n < 9; n++) begin
                wr(ADDR_MAIN_CTRL, 32'(n));
                rd(ADDR_COUNTER, c0);
                idle(200);
                rd(ADDR_COUNTER, c1);
                d  = c1[7:0] - c0[7:0];
                ex = (204 >> (n - 1)) >> s;
                check(32'(int'(d) >= ex - 1 && int'(d) <= ex + 1), 32'h1, "tick rate");
            end
        end
        async_source_enable <= 1'b0;
        wr(ADDR_MAIN_CTRL, 32'h08);
        wr(ADDR_GEN_CTRL, 32'h02);
        rd(ADDR_COUNTER, c0);
        idle(100);
        rd(ADDR_COUNTER, c1);
        check(c1, c0, "prescaler restarted");
        wr(ADDR_MAIN_CTRL, 32'h0f);
        wr(ADDR_GEN_CTRL, 32'h02);
        rd(ADDR_COUNTER, c0);
        idle(16384);
        rd(ADDR_COUNTER, c1);
        d = c1[7:0] - c0[7:0];
        check(32'(d == 8'h1 || d == 8'h2), 32'h1, "slowest rate");
        wr(ADDR_MAIN_CTRL, 32'h0);
        wr(ADDR_CMP_A, 32'h40);
        wr(ADDR_CMP_B, 32'h50);
        wr(ADDR_CMP_C, 32'hff);
        wr(ADDR_FLAGS, 32'h60);
        wr(ADDR_COUNTER, 32'h40);
        idle(10);
        rd(ADDR_FLAGS, v);
        check(v, 32'h0, "no match from load");
        wr(ADDR_IRQ_MASK, 32'h60);
        global_irq_enable <= 1'b1;
        wr(ADDR_COUNTER, 32'h30);
        wr(ADDR_MAIN_CTRL, 32'h01);
        for (k = 0; k < 100 && irq_compare_a !== 1'b1; k++) @(posedge pclk);
        idle(2);
        check(32'({irq_compare_a, irq_vector}), 32'({1'b1, VECTOR_CMP_A}),
              "A request");
        for (k = 0; k < 100 && irq_compare_b !== 1'b1; k++) @(posedge pclk);
        idle(2);
        check(32'({irq_compare_b, irq_vector}), 32'({1'b1, VECTOR_CMP_A}),
              "A before B");
        wr(ADDR_MAIN_CTRL, 32'h0);
        rd(ADDR_FLAGS, v);
        check(v, 32'h60, "both flags");
        wr(ADDR_FLAGS, 32'h40);
        idle(4);
        check(32'({irq_compare_a, irq_vector}), 32'({1'b0, VECTOR_CMP_B}),
              "B request");
        wr(ADDR_FLAGS, 32'h20);
        global_irq_enable <= 1'b0;
        // Toggle mode on B so the one B match below must flip the pin
        wr(ADDR_GEN_CTRL, 32'h10);
        wr(ADDR_COUNTER, 32'h3e);
        wr(ADDR_MAIN_CTRL, 32'h01);
        idle(20);
        wr(ADDR_MAIN_CTRL, 32'h0);
        rd(ADDR_FLAGS, v);
        check(32'({v[7:0], irq_compare_a, irq_compare_b}), 32'h180,
              "global bit off");
        check(32'(compare_b_pin), 32'h1, "B toggled on match");
        wr(ADDR_FLAGS, 32'h60);
        wr(ADDR_IRQ_MASK, 32'h0);
        wr(ADDR_CMP_C, 32'h20);
        wr(ADDR_COUNTER, 32'h0);
        for (s = 0; s < 2; s++) begin
            wr(ADDR_GEN_CTRL, s ? 32'h40 : 32'h0);
            wr(ADDR_MAIN_CTRL, s ? 32'h01 : 32'h81);
            mx = 8'h0;
            repeat (40) begin
                rd(ADDR_COUNTER, v);
                if (v[7:0] > mx) mx = v[7:0];
            end
            check(32'(mx), 32'h20, "counter top");
        end
        wr(ADDR_GEN_CTRL, 32'h0);
        wr(ADDR_MAIN_CTRL, 32'h0);
        wr(ADDR_CMP_C, 32'hff);
        wr(ADDR_FLAGS, 32'h60);
        dir_a <= 1'b1;
        dir_b <= 1'b1;
        // Mode and force strobe go together for B; A takes its stored mode
        for (k = 0; k < 5; k++) begin
            wr(ADDR_MAIN_CTRL, 32'(modes[k]) << COM_A_LO);
            wr(ADDR_GEN_CTRL, 32'h04);
            wr(ADDR_GEN_CTRL, (32'(modes[k]) << COM_B_LO) | 32'h08);
            idle(3);
            check(32'({compare_a_pin_oe, compare_b_pin_oe}), {30'h0, {2{k < 4}}}, "pin enable");
            if (k < 4) check(32'({compare_a_pin, compare_b_pin}), {30'h0, {2{pins[k]}}},
                             "forced pin");
            check(32'(compare_b_pin_n_oe), 32'h0, "inverted B idle");
            if (k < 4) check(32'(compare_b_pin_n), 32'(!pins[k]), "inverted B level");
        end
        rd(ADDR_FLAGS, v);
        check(v, 32'h0, "force sets no flag");
        dir_b <= 1'b0;
        wr(ADDR_GEN_CTRL, 32'h38);
        idle(3);
        check(32'(compare_b_pin_oe), 32'h0, "direction off");
        give_verdict();
    end
endmodule : timer1_prescale_compare_regs_test
`default_nettype wire
